// >>> core/anc_pkg.sv
package anc_pkg;
	// Error codes reported to software
	localparam logic [15:0] ERR_NONE      = 16'h0000;
	localparam logic [15:0] ERR_CONV      = 16'h7F20;
	localparam logic [15:0] ERR_DIGCNT    = 16'h7D19;
	localparam logic [15:0] ERR_FEWDIG    = 16'h7D18;
	localparam logic [15:0] ERR_DPPOS     = 16'h7D21;
	// Digit limits for variable digit count
	localparam logic [3:0]  MAX_DEC_WORD  = 4'h5;
	localparam logic [3:0]  MAX_HEX_WORD  = 4'h4;
	localparam logic [3:0]  MAX_DEC_DWORD = 4'hA;
	localparam logic [3:0]  MAX_HEX_DWORD = 4'h8;
	// Character codes
	localparam logic [7:0]  CH_PLUS       = 8'h2B;
	localparam logic [7:0]  CH_MINUS      = 8'h2D;
	localparam logic [7:0]  CH_PERIOD     = 8'h2E;
	localparam logic [7:0]  CH_COMMA      = 8'h2C;
	localparam logic [7:0]  CH_SPACE      = 8'h20;
	// Delimiter selection
	localparam logic [1:0]  DLM_NONE      = 2'h0;
	localparam logic [1:0]  DLM_COMMA     = 2'h1;
	localparam logic [1:0]  DLM_SPACE     = 2'h2;
	// Reset values
	localparam logic [31:0] ACC_RST       = 32'h0000_0000;
	localparam logic [31:0] SCALE_ONE     = 32'h0000_0001;
	localparam logic [3:0]  CNT_RST       = 4'h0;
	localparam logic [15:0] ITEMS_RST     = 16'h0000;
	// Output word kinds
	typedef enum logic [1:0] {
		OUT_VALUE = 2'h0,
		OUT_POINT = 2'h1,
		OUT_COUNT = 2'h2
	} anc_kind_t;
	typedef enum logic [3:0] {
		ST_IDLE  = 4'b0001,
		ST_ITEM  = 4'b0010,
		ST_ERROR = 4'b0100,
		ST_DONE  = 4'b1000
	} anc_state_t;
endpackage : anc_pkg

// >>> core/anc_skid.sv
`timescale 1ns/10ps
module anc_skid #(
	parameter int W = 34
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] in_data,
	input  wire logic         in_valid,
	output logic              in_ready,
	output logic      [W-1:0] out_data,
	output logic              out_valid,
	input  wire logic         out_ready
);
	// Two entries: a stall by the reader never drops the word in flight
	logic [W-1:0] mem_r [2];
	logic [W-1:0] mem_nxt [2];
	logic         wp_r, wp_nxt, rp_r, rp_nxt;
	logic [1:0]   cnt_r, cnt_nxt;
	logic         push, pop;

	assign in_ready  = (cnt_r != 2'h2);
	assign out_valid = (cnt_r != 2'h0);
	assign out_data  = mem_r[rp_r];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always_comb begin
		mem_nxt = mem_r;
		wp_nxt  = wp_r;
		rp_nxt  = rp_r;
		cnt_nxt = cnt_r;
		if (push) begin
			mem_nxt[wp_r] = in_data;
			wp_nxt        = ~wp_r;
		end
		if (pop) begin
			rp_nxt = ~rp_r;
		end
		if (push && !pop) begin
			cnt_nxt = cnt_r + 2'h1;
		end else if (pop && !push) begin
			cnt_nxt = cnt_r - 2'h1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mem_r[0] <= '0;
			mem_r[1] <= '0;
			wp_r     <= 1'b0;
			rp_r     <= 1'b0;
			cnt_r    <= 2'h0;
		end else begin
			mem_r <= mem_nxt;
			wp_r  <= wp_nxt;
			rp_r  <= rp_nxt;
			cnt_r <= cnt_nxt;
		end
	end
endmodule : anc_skid

// >>> core/anc_converter.sv
`timescale 1ns/10ps
// Function
// - Hex mode: non-hex character gives 7F20
// - Decimal mode: stray non-digit gives 7F20
// - Sign accepted only as first character
// - Period only at configured digit position
// - Variable point: period not first or last
// - Delimiter accepted only between items
// - Word: over 5 dec/4 hex digits
// - Dword: over 10 dec/8 hex digits
// - Send, variable point: point position above digits gives 7D21
// - Fixed items, variable digits: zero digits error
// - Variable items: too few digits gives 7D18
// - Variable count: items first, count word after
// - Point position stored as power of ten
module anc_converter (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        cfg_hex,
	input  wire logic        cfg_dword,
	input  wire logic        cfg_signed,
	input  wire logic        cfg_var_point,
	input  wire logic [3:0]  cfg_decimals,
	input  wire logic [1:0]  cfg_delim,
	input  wire logic        cfg_var_digits,
	input  wire logic [3:0]  cfg_digits,
	input  wire logic        cfg_var_items,
	input  wire logic [15:0] cfg_items,
	input  wire logic        start,
	input  wire logic [7:0]  rx_char,
	input  wire logic        rx_valid,
	output logic             rx_ready,
	input  wire logic        rx_end,
	output logic [31:0]      out_data,
	output logic [1:0]       out_kind,
	output logic             out_valid,
	input  wire logic        out_ready,
	output logic             busy,
	output logic             done,
	output logic             err,
	output logic [15:0]      err_code,
	input  wire logic        tx_check,
	input  wire logic [3:0]  tx_point_pos,
	output logic             tx_err,
	output logic [15:0]      tx_err_code
);
	anc_pkg::anc_state_t st_r, st_nxt;
	logic [31:0] acc_r, acc_nxt, scale_r, scale_nxt;
	logic [3:0]  ndig_r, ndig_nxt, nch_r, nch_nxt;
	logic        neg_r, neg_nxt, pt_r, pt_nxt, lastpt_r, lastpt_nxt;
	logic [15:0] items_r, items_nxt, code_r, code_nxt;
	logic        done_r, done_nxt;
	logic        cnt_pend_r, cnt_pend_nxt;
	logic [33:0] bw_data, bb_data;
	logic        bw_valid, bw_ready;
	logic        txe_r;
	logic [15:0] txc_r;

	logic        is_dig, is_hexl, is_hexu, is_sign, is_pt, is_dlm;
	logic [3:0]  nib, maxd;
	logic        take, item_end, all_end;
	logic [31:0] mult, vout;

	always_comb begin
		is_dig  = (rx_char >= 8'h30) && (rx_char <= 8'h39);
		is_hexu = (rx_char >= 8'h41) && (rx_char <= 8'h46);
		is_hexl = (rx_char >= 8'h61) && (rx_char <= 8'h66);
		is_sign = (rx_char == anc_pkg::CH_PLUS) || (rx_char == anc_pkg::CH_MINUS);
		is_pt   = (rx_char == anc_pkg::CH_PERIOD);
		is_dlm  = ((cfg_delim == anc_pkg::DLM_COMMA) && (rx_char == anc_pkg::CH_COMMA)) ||
			((cfg_delim == anc_pkg::DLM_SPACE) && (rx_char == anc_pkg::CH_SPACE));
		// Lowercase folds onto uppercase by the low nibble plus nine
		if (is_dig) begin
			nib = rx_char[3:0];
		end else begin
			nib = rx_char[3:0] + 4'h9;
		end
		if (cfg_dword) begin
			maxd = cfg_hex ? anc_pkg::MAX_HEX_DWORD : anc_pkg::MAX_DEC_DWORD;
		end else begin
			maxd = cfg_hex ? anc_pkg::MAX_HEX_WORD : anc_pkg::MAX_DEC_WORD;
		end
		mult = cfg_hex ? {acc_r[27:0], 4'h0} : ({acc_r[28:0], 3'h0} + {acc_r[30:0], 1'b0});
		vout = neg_r ? (~acc_r + 32'h1) : acc_r;
	end

	// Input stalls while a point or count word waits for buffer room
	assign take     = (st_r == anc_pkg::ST_ITEM) && rx_valid && bw_ready && !cnt_pend_r;
	assign rx_ready = take;
	assign item_end = take && (is_dlm || rx_end);
	assign all_end  = !cfg_var_items && (items_r + 16'h1 == cfg_items);

	always_comb begin
		st_nxt       = st_r;
		acc_nxt      = acc_r;
		scale_nxt    = scale_r;
		ndig_nxt     = ndig_r;
		nch_nxt      = nch_r;
		neg_nxt      = neg_r;
		pt_nxt       = pt_r;
		lastpt_nxt   = lastpt_r;
		items_nxt    = items_r;
		code_nxt     = code_r;
		done_nxt     = 1'b0;
		cnt_pend_nxt = cnt_pend_r;
		bw_valid     = 1'b0;
		bw_data      = {anc_pkg::OUT_VALUE, vout};
		case (st_r)
			anc_pkg::ST_IDLE, anc_pkg::ST_ERROR, anc_pkg::ST_DONE: begin
				if (start) begin
					st_nxt     = anc_pkg::ST_ITEM;
					acc_nxt    = anc_pkg::ACC_RST;
					scale_nxt  = anc_pkg::SCALE_ONE;
					ndig_nxt   = anc_pkg::CNT_RST;
					nch_nxt    = anc_pkg::CNT_RST;
					neg_nxt    = 1'b0;
					pt_nxt     = 1'b0;
					lastpt_nxt = 1'b0;
					items_nxt  = anc_pkg::ITEMS_RST;
					code_nxt   = anc_pkg::ERR_NONE;
				end
			end
			anc_pkg::ST_ITEM: begin
				if (cnt_pend_r) begin
					// Count word follows the stored items
					bw_valid = 1'b1;
					bw_data  = {anc_pkg::OUT_COUNT, 16'h0000, items_r};
					if (bw_ready) begin
						cnt_pend_nxt = 1'b0;
						st_nxt       = anc_pkg::ST_DONE;
						done_nxt     = 1'b1;
					end
				end else if (take && !item_end) begin
					nch_nxt    = nch_r + 4'h1;
					lastpt_nxt = 1'b0;
					if (is_dig || (cfg_hex && (is_hexu || is_hexl))) begin
						if (ndig_r == maxd && cfg_var_digits) begin
							code_nxt = anc_pkg::ERR_DIGCNT;
						end else begin
							acc_nxt  = mult + {28'h0, nib};
							ndig_nxt = ndig_r + 4'h1;
							if (pt_r) begin
								scale_nxt = {scale_r[28:0], 3'h0} + {scale_r[30:0], 1'b0};
							end
						end
					end else if (!cfg_hex && is_sign && cfg_signed) begin
						if (nch_r != 4'h0) begin
							code_nxt = anc_pkg::ERR_CONV;
						end
						neg_nxt = (rx_char == anc_pkg::CH_MINUS);
					end else if (!cfg_hex && is_pt && (cfg_var_point || cfg_decimals != 4'h0)) begin
						if (pt_r || ndig_r == 4'h0) begin
							code_nxt = anc_pkg::ERR_CONV;
						end else if (!cfg_var_point && ndig_r != cfg_digits - cfg_decimals) begin
							code_nxt = anc_pkg::ERR_CONV;
						end
						pt_nxt     = 1'b1;
						lastpt_nxt = 1'b1;
					end else begin
						code_nxt = anc_pkg::ERR_CONV;
					end
				end else if (item_end) begin
					if (is_dlm && nch_r == 4'h0) begin
						code_nxt = anc_pkg::ERR_CONV;
					end else if (lastpt_r) begin
						code_nxt = anc_pkg::ERR_CONV;
					end else if (ndig_r == 4'h0 && cfg_var_digits && !cfg_var_items) begin
						code_nxt = anc_pkg::ERR_DIGCNT;
					end else if (cfg_var_items && ndig_r < cfg_digits) begin
						code_nxt = anc_pkg::ERR_FEWDIG;
					end else if (is_dlm && all_end) begin
						code_nxt = anc_pkg::ERR_CONV;
					end else begin
						bw_valid  = 1'b1;
						items_nxt = items_r + 16'h1;
						acc_nxt   = anc_pkg::ACC_RST;
						ndig_nxt  = anc_pkg::CNT_RST;
						nch_nxt   = anc_pkg::CNT_RST;
						neg_nxt   = 1'b0;
						pt_nxt    = 1'b0;
						if (cfg_var_point) begin
							scale_nxt    = anc_pkg::SCALE_ONE;
							cnt_pend_nxt = 1'b0;
						end
						if (rx_end || all_end) begin
							if (cfg_var_items) begin
								cnt_pend_nxt = 1'b1;
							end else begin
								st_nxt   = anc_pkg::ST_DONE;
								done_nxt = 1'b1;
							end
						end
					end
				end
				if (code_nxt != anc_pkg::ERR_NONE) begin
					st_nxt = anc_pkg::ST_ERROR;
				end
			end
			default: begin
				st_nxt = anc_pkg::ST_IDLE;
			end
		endcase
	end

	// Point position follows the value, a one-entry stage keeps it from being dropped
	logic        pp_r, pp_nxt;
	logic [31:0] ppv_r, ppv_nxt;
	logic [33:0] feed;
	logic        feed_v, feed_rdy;
	always_comb begin
		pp_nxt  = pp_r;
		ppv_nxt = ppv_r;
		feed    = pp_r ? {anc_pkg::OUT_POINT, ppv_r} : bw_data;
		feed_v  = pp_r | bw_valid;
		if (pp_r && feed_rdy) begin
			pp_nxt = 1'b0;
		end else if (bw_valid && feed_rdy && cfg_var_point && bw_data[33:32] == anc_pkg::OUT_VALUE) begin
			pp_nxt  = 1'b1;
			ppv_nxt = scale_r;
		end
	end
	assign bw_ready = feed_rdy && !pp_r;

	anc_skid #(
		.W(34)
	) u_buf (
		.clk       (clk),
		.rst       (rst),
		.in_data   (feed),
		.in_valid  (feed_v),
		.in_ready  (feed_rdy),
		.out_data  (bb_data),
		.out_valid (out_valid),
		.out_ready (out_ready)
	);
	assign out_data = bb_data[31:0];
	assign out_kind = bb_data[33:32];

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_r       <= anc_pkg::ST_IDLE;
			acc_r      <= anc_pkg::ACC_RST;
			scale_r    <= anc_pkg::SCALE_ONE;
			ndig_r     <= anc_pkg::CNT_RST;
			nch_r      <= anc_pkg::CNT_RST;
			neg_r      <= 1'b0;
			pt_r       <= 1'b0;
			lastpt_r   <= 1'b0;
			items_r    <= anc_pkg::ITEMS_RST;
			code_r     <= anc_pkg::ERR_NONE;
			done_r     <= 1'b0;
			cnt_pend_r <= 1'b0;
			pp_r       <= 1'b0;
			ppv_r      <= anc_pkg::SCALE_ONE;
		end else begin
			st_r       <= st_nxt;
			acc_r      <= acc_nxt;
			scale_r    <= scale_nxt;
			ndig_r     <= ndig_nxt;
			nch_r      <= nch_nxt;
			neg_r      <= neg_nxt;
			pt_r       <= pt_nxt;
			lastpt_r   <= lastpt_nxt;
			items_r    <= items_nxt;
			code_r     <= code_nxt;
			done_r     <= done_nxt;
			cnt_pend_r <= cnt_pend_nxt;
			pp_r       <= pp_nxt;
			ppv_r      <= ppv_nxt;
		end
	end

	assign busy     = (st_r == anc_pkg::ST_ITEM);
	assign done     = done_r;
	assign err      = (st_r == anc_pkg::ST_ERROR);
	assign err_code = code_r;

	// Send-side check is registered so the code stands one cycle after the strobe
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			txe_r <= 1'b0;
			txc_r <= anc_pkg::ERR_NONE;
		end else if (tx_check) begin
			txe_r <= cfg_var_point && (tx_point_pos > cfg_digits);
			txc_r <= (cfg_var_point && (tx_point_pos > cfg_digits)) ? anc_pkg::ERR_DPPOS
				: anc_pkg::ERR_NONE;
		end
	end
	assign tx_err      = txe_r;
	assign tx_err_code = txc_r;
endmodule : anc_converter

// >>> test/anc_converter_properties.sv
`timescale 1ns/10ps
module anc_chk (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        cfg_hex,
	input  wire logic        cfg_var_point,
	input  wire logic [1:0]  cfg_delim,
	input  wire logic [3:0]  cfg_digits,
	input  wire logic        start,
	input  wire logic [7:0]  rx_char,
	input  wire logic        rx_valid,
	input  wire logic        rx_ready,
	input  wire logic        rx_end,
	input  wire logic [31:0] out_data,
	input  wire logic        out_valid,
	input  wire logic        out_ready,
	input  wire logic        busy,
	input  wire logic        done,
	input  wire logic        err,
	input  wire logic [15:0] err_code,
	input  wire logic        tx_check,
	input  wire logic [3:0]  tx_point_pos,
	input  wire logic [15:0] tx_err_code
);
	logic dig, hexl, dlm, spec, fresh_r, fresh_nxt;
	assign dig = rx_char >= 8'h30 && rx_char <= 8'h39;
	assign hexl = (rx_char | 8'h20) >= 8'h61 && (rx_char | 8'h20) <= 8'h66;
	assign dlm = (cfg_delim == anc_pkg::DLM_COMMA && rx_char == anc_pkg::CH_COMMA)
		|| (cfg_delim == anc_pkg::DLM_SPACE && rx_char == anc_pkg::CH_SPACE);
	assign spec = rx_char inside {anc_pkg::CH_PLUS, anc_pkg::CH_MINUS, anc_pkg::CH_PERIOD};
	// First character after start; a delimiter there has no item before it
	always_comb fresh_nxt = start ? 1'b1 : (busy && rx_valid && rx_ready) ? 1'b0 : fresh_r;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) fresh_r <= 1'b0;
		else fresh_r <= fresh_nxt;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_take;
		busy && rx_valid && rx_ready && !rx_end;
	endsequence
	sequence s_conv_err;
		err && err_code == anc_pkg::ERR_CONV;
	endsequence
	hex_char_a: assert property (s_take ##0 (cfg_hex && !dig && !hexl && !dlm) |=> s_conv_err)
		else $error("bad hex char accepted");
	dec_char_a: assert property (s_take ##0 (!cfg_hex && !dig && !dlm && !spec) |=> s_conv_err)
		else $error("bad decimal char accepted");
	sign_pos_a: assert property (s_take ##0 dig ##1 s_take ##0 rx_char == anc_pkg::CH_MINUS
		|=> s_conv_err) else $error("inner sign accepted");
	lead_delim_a: assert property (s_take ##0 (fresh_r && dlm) |=> s_conv_err)
		else $error("leading delimiter accepted");
	idle_refuse_a: assert property (!busy |-> !rx_ready)
		else $error("char taken while idle");
	err_hold_a: assert property (err && !start |=> err && $stable(err_code))
		else $error("error not held");
	tx_point_a: assert property (tx_check |=> tx_err_code == (($past(cfg_var_point)
		&& $past(tx_point_pos) > $past(cfg_digits)) ? anc_pkg::ERR_DPPOS : anc_pkg::ERR_NONE))
		else $error("send point check wrong");
	buf_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
		else $error("stalled word lost");
	done_pulse_a: assert property (done |=> !done)
		else $error("done longer than one cycle");
endmodule : anc_chk
bind anc_converter anc_chk u_chk (.clk(clk), .rst(rst), .cfg_hex(cfg_hex),
	.cfg_var_point(cfg_var_point),
	.cfg_delim(cfg_delim), .cfg_digits(cfg_digits), .start(start), .rx_char(rx_char),
	.rx_valid(rx_valid), .rx_ready(rx_ready), .rx_end(rx_end), .out_data(out_data),
	.out_valid(out_valid), .out_ready(out_ready), .busy(busy), .done(done), .err(err),
	.err_code(err_code), .tx_check(tx_check), .tx_point_pos(tx_point_pos),
	.tx_err_code(tx_err_code));

// >>> test/anc_line_model.sv
`timescale 1ns/10ps
module anc_line_model (
	input  wire logic       clk,
	input  wire logic       rx_ready,
	input  wire logic       hold,
	output logic      [7:0] rx_char,
	output logic            rx_valid,
	output logic            rx_end,
	output logic            out_ready
);
	// A stalled reader lets the two-entry buffer fill and push back on the line
	assign out_ready = !hold;
	initial begin
		rx_char = 8'h00;
		rx_valid = 1'b0;
		rx_end = 1'b0;
	end
	// Idle line shows the inverse of the last character, never a stale copy
	task automatic send(input string s, input logic e, output bit ok);
		int i;
		int n;
		ok = 1'b1;
		for (i = 0; i < s.len() && ok; i++) begin
			rx_char = s[i];
			rx_valid = 1'b1;
			rx_end = e && i == s.len() - 1;
			ok = 1'b0;
			for (n = 0; n < 200 && !ok; n++) begin
				@(posedge clk);
				ok = rx_ready;
			end
			#1;
		end
		rx_valid = 1'b0;
		rx_end = 1'b0;
		rx_char = ~rx_char;
	endtask : send
endmodule : anc_line_model

// >>> test/testbench.sv
`timescale 1ns/10ps
module testbench;
	logic        clk, rst, cfg_hex, cfg_dword, cfg_signed, cfg_var_point, cfg_var_digits;
	logic        cfg_var_items, start, rx_valid, rx_ready, rx_end, out_valid, out_ready;
	logic        busy, done, err, tx_check, tx_err, hold, done_seen, refused;
	logic [3:0]  cfg_decimals, cfg_digits, tx_point_pos;
	logic [1:0]  cfg_delim, out_kind;
	logic [15:0] cfg_items, err_code, tx_err_code;
	logic [7:0]  rx_char;
	logic [31:0] out_data, mask, rnd;
	logic [33:0] exp_q[$];
	int          bad_count, check_count;
	anc_converter u_dut (.clk(clk), .rst(rst), .cfg_hex(cfg_hex), .cfg_dword(cfg_dword),
		.cfg_signed(cfg_signed), .cfg_var_point(cfg_var_point), .cfg_decimals(cfg_decimals),
		.cfg_delim(cfg_delim), .cfg_var_digits(cfg_var_digits), .cfg_digits(cfg_digits),
		.cfg_var_items(cfg_var_items), .cfg_items(cfg_items), .start(start), .rx_char(rx_char),
		.rx_valid(rx_valid), .rx_ready(rx_ready), .rx_end(rx_end), .out_data(out_data),
		.out_kind(out_kind), .out_valid(out_valid), .out_ready(out_ready), .busy(busy),
		.done(done), .err(err), .err_code(err_code), .tx_check(tx_check),
		.tx_point_pos(tx_point_pos), .tx_err(tx_err), .tx_err_code(tx_err_code));
	anc_line_model u_line (.clk(clk), .rx_ready(rx_ready), .hold(hold), .rx_char(rx_char),
		.rx_valid(rx_valid), .rx_end(rx_end), .out_ready(out_ready));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// Word results are compared on their low half only, sign fill is not defined
	assign mask = cfg_dword ? 32'hFFFFFFFF : 32'h0000FFFF;
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction : lfsr
	task chk(input logic [33:0] g, input logic [33:0] w);
		check_count++;
		if (g !== w) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, g, w);
		end
	endtask : chk
	task conclude;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask : conclude
	task automatic model(input string s, input logic e);
		longint v;
		int i, fr, n;
		bit pt, ng;
		byte c;
		{v, fr, n, pt, ng} = '0;
		for (i = 0; i <= s.len(); i++) begin
			c = (i < s.len()) ? s[i] : 8'h00;
			if (i == s.len() ? !e : ((e && i == s.len() - 1) || c == ",")) begin
				exp_q.push_back({2'h0, 32'(ng ? -v : v) & mask});
				if (cfg_var_point) exp_q.push_back({2'h1, 32'(10 ** fr)});
				n++;
				{v, fr, pt, ng} = '0;
			end else if (c == "-") ng = 1'b1;
			else if (c == ".") pt = 1'b1;
			else if (i < s.len()) begin
				v = v * (cfg_hex ? 16 : 10) + (c >= "a" ? c - 87 : c >= "A" ? c - 55 : c - 48);
				fr += pt;
			end
		end
		if (cfg_var_items) exp_q.push_back({2'h2, 32'(n)});
	endtask : model
	task automatic go(input string s, input logic e, input logic [15:0] code);
		bit ok;
		int n;
		if (code === anc_pkg::ERR_NONE) model(s, e);
		done_seen = 1'b0;
		start = 1'b1;
		@(posedge clk);
		#1 start = 1'b0;
		u_line.send(s, e, ok);
		for (n = 0; n < 99 && (exp_q.size() > 0 || !(code != 0 ? err : done_seen)); n++) begin
			@(posedge clk);
			#1;
		end
		chk({16'h0, err, ok || code != 0, err_code}, {16'h0, code != 0, 1'b1, code});
		if (n == 99) begin
			bad_count++;
			conclude();
		end
	endtask : go
	always @(posedge clk) begin
		if (done) done_seen = 1'b1;
		if (rx_valid && !rx_ready && busy) refused = 1'b1;
		if (out_valid && out_ready)
			chk({out_kind, out_data & mask}, exp_q.size() ? exp_q.pop_front() : '1);
	end
	initial begin
		string s;
		int k, p;
		{rst, cfg_var_digits, cfg_delim} = 4'hF;
		{cfg_hex, cfg_dword, cfg_signed, cfg_var_point, cfg_var_items, start, tx_check} = '0;
		{hold, refused, cfg_decimals, tx_point_pos} = '0;
		{bad_count, check_count} = '0;
		cfg_delim = anc_pkg::DLM_COMMA;
		cfg_digits = 4'h5;
		cfg_items = 16'h0002;
		rnd = 32'h0001_3018;
		repeat (2) @(posedge clk);
		#1 rst = 1'b0;
		go("12,34;", 1, anc_pkg::ERR_NONE);
		go(",1;", 1, anc_pkg::ERR_CONV);
		cfg_delim = anc_pkg::DLM_SPACE;
		go(" 1;", 1, anc_pkg::ERR_CONV);
		cfg_delim = anc_pkg::DLM_COMMA;
		go("1A;", 1, anc_pkg::ERR_CONV);
		cfg_signed = 1'b1;
		go("-5,7;", 1, anc_pkg::ERR_NONE);
		go("1-2;", 1, anc_pkg::ERR_CONV);
		{cfg_hex, cfg_signed} = 2'h2;
		go("aF,b0;", 1, anc_pkg::ERR_NONE);
		go("1G;", 1, anc_pkg::ERR_CONV);
		{cfg_hex, cfg_var_point} = 2'h1;
		go("12.5,3;", 1, anc_pkg::ERR_NONE);
		go(".5;", 1, anc_pkg::ERR_CONV);
		go("5.,1;", 1, anc_pkg::ERR_CONV);
		{cfg_var_point, cfg_var_digits, cfg_decimals, cfg_digits, cfg_items} = {6'h1, 4'h3, 16'h1};
		// Fixed point, three digits with one decimal: the period is accepted only after the second digit
		go("12.5;", 1, anc_pkg::ERR_NONE);
		go("1.25;", 1, anc_pkg::ERR_CONV);
		{cfg_decimals, cfg_var_digits} = 5'h1;
		for (k = 0; k < 4; k++) begin
			{cfg_dword, cfg_hex} = 2'(k);
			s = "1";
			repeat ((k == 0) ? 5 : (k == 1) ? 4 : (k == 2) ? 10 : 8) s = {s, "1"};
			go({s, ";"}, 1, anc_pkg::ERR_DIGCNT);
		end
		go(";", 1, anc_pkg::ERR_DIGCNT);
		{cfg_dword, cfg_hex, cfg_var_digits, cfg_var_items, cfg_digits} = {4'h1, 4'h2};
		go("12,34;", 1, anc_pkg::ERR_NONE);
		go("1;", 1, anc_pkg::ERR_FEWDIG);
		{cfg_var_items, cfg_var_digits, cfg_items} = {2'h1, 16'h4};
		s = "";
		for (k = 0; k < 4; k++) begin
			rnd = lfsr(rnd);
			s = $sformatf("%s%0d%s", s, rnd % 100, (k < 3) ? "," : ";");
		end
		// Earlier point stalls also refuse, so only this stall may count
		refused = 1'b0;
		fork
			begin
				hold = 1'b1;
				repeat (20) @(posedge clk);
				#1 hold = 1'b0;
			end
		join_none
		go(s, 1, anc_pkg::ERR_NONE);
		chk({33'h0, refused}, {33'h0, 1'b1});
		{cfg_var_point, cfg_digits} = 5'h15;
		for (p = 0; p < 16; p++) begin
			tx_point_pos = 4'(p);
			tx_check = 1'b1;
			@(posedge clk);
			#1 tx_check = 1'b0;
			@(posedge clk);
			#1 chk({17'h0, tx_err, tx_err_code}, {17'h0, p > 5, p > 5 ? 16'h7D21 : 16'h0000});
		end
		conclude();
	end
endmodule : testbench
